// ---- hdl/psw_access_entity.sv ----
`include "psw_params.svh"
module psw_access_entity import psw_pkg::*; #(
	parameter logic [`PSW_TIMER_WIDTH-1:0] REQ_GUARD = `PSW_REQ_GUARD_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire psw_msg_t i_rx,
	input wire psw_mgmt_req_t i_mgmt,
	output psw_msg_t o_tx,
	output psw_mgmt_ind_t o_ind,
	output psw_access_state_t o_state
);
	typedef struct packed
	{
		psw_access_state_t fsm;
		logic last_was_os;
		logic [7:0] channel;
		logic [4:0] link_id;
		logic [4:0] time_slot;
		psw_msg_t tx;
		psw_mgmt_ind_t ind;
		logic req_start;
		logic req_stop;
	} psw_acc_state_t;
	psw_acc_state_t state_reg;
	psw_acc_state_t state_next;
	logic req_first;
	logic req_second;
	psw_guard_timer #(.CYCLES(REQ_GUARD)) u_request_guard_timer (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_start(state_reg.req_start),
		.i_stop(state_reg.req_stop),
		.o_first_expiry(req_first),
		.o_second_expiry(req_second),
		.o_running()
	);
	assign o_tx = state_reg.tx;
	assign o_ind = state_reg.ind;
	assign o_state = state_reg.fsm;
	always_comb
	begin
		state_next = state_reg;
		state_next.tx = '0;
		state_next.ind = '0;
		state_next.req_start = 1'b0;
		state_next.req_stop = 1'b0;
		case (state_reg.fsm)
			access_null_state:
			begin
				if (i_rx.valid && (i_rx.kind == psw_msg_os_com || i_rx.kind == psw_msg_com))
				begin
					state_next.fsm = access_commanded_state;
					state_next.last_was_os = (i_rx.kind == psw_msg_os_com);
					state_next.ind.os_com_ind = (i_rx.kind == psw_msg_os_com);
					state_next.ind.com_ind = (i_rx.kind == psw_msg_com);
				end
				else if (i_mgmt.switch_req)
				begin
					state_next.fsm = access_requested_state;
					state_next.channel = i_mgmt.logical_channel;
					state_next.link_id = i_mgmt.has_preference ? i_mgmt.link_id : 5'h00;
					state_next.time_slot = i_mgmt.has_preference ? i_mgmt.time_slot : 5'h00;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_req;
					state_next.tx.logical_channel = i_mgmt.logical_channel;
					state_next.tx.link_id = i_mgmt.has_preference ? i_mgmt.link_id : 5'h00;
					state_next.tx.time_slot = i_mgmt.has_preference ? i_mgmt.time_slot : 5'h00;
					state_next.req_start = 1'b1;
				end
			end
			access_requested_state:
			begin
				if (i_rx.valid && (i_rx.kind == psw_msg_os_com || i_rx.kind == psw_msg_com))
				begin
					state_next.fsm = access_commanded_state;
					state_next.last_was_os = (i_rx.kind == psw_msg_os_com);
					state_next.ind.os_com_ind = (i_rx.kind == psw_msg_os_com);
					state_next.ind.com_ind = (i_rx.kind == psw_msg_com);
					state_next.req_stop = 1'b1;
				end
				else if (i_rx.valid && i_rx.kind == psw_msg_reject)
				begin
					state_next.fsm = access_null_state;
					state_next.ind.reject_ind = 1'b1;
					state_next.ind.cause = i_rx.cause;
					state_next.req_stop = 1'b1;
				end
				else if (req_first)
				begin
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_req;
					state_next.tx.logical_channel = state_reg.channel;
					state_next.tx.link_id = state_reg.link_id;
					state_next.tx.time_slot = state_reg.time_slot;
					state_next.req_start = 1'b1;
				end
				else if (req_second)
				begin
					state_next.fsm = access_null_state;
					state_next.ind.error_ind = 1'b1;
				end
			end
			access_commanded_state:
			begin
				if (i_mgmt.accept)
				begin
					state_next.fsm = access_null_state;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_ack;
					state_next.tx.logical_channel = state_reg.channel;
				end
				else if (i_mgmt.refuse)
				begin
					state_next.fsm = access_null_state;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_reject;
					state_next.tx.logical_channel = state_reg.channel;
					// occupied target is no reason to refuse a pre-empting command
					state_next.tx.cause = (state_reg.last_was_os &&
						i_mgmt.cause == `PSW_CAUSE_TARGET_OCCUPIED) ?
						`PSW_CAUSE_NOT_ALLOWED : i_mgmt.cause;
				end
			end
			default:
			begin
				state_next.fsm = access_null_state;
			end
		endcase
		// anything else falls through with no change
	end
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg <= '0;
			state_reg.fsm <= access_null_state;
		end
		else
		begin
			state_reg <= state_next;
		end
	end
endmodule

// ---- hdl/psw_exchange_entity.sv ----
`include "psw_params.svh"
module psw_exchange_entity import psw_pkg::*; #(
	parameter logic [`PSW_TIMER_WIDTH-1:0] STD_GUARD = `PSW_STD_GUARD_CYCLES,
	parameter logic [`PSW_TIMER_WIDTH-1:0] OPR_GUARD = `PSW_OPR_GUARD_CYCLES,
	parameter logic [`PSW_TIMER_WIDTH-1:0] REQ_GUARD = `PSW_REQ_GUARD_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire psw_msg_t i_exch_rx,
	input wire psw_mgmt_req_t i_exch_mgmt,
	output psw_msg_t o_exch_tx,
	output psw_mgmt_ind_t o_exch_ind,
	output psw_exch_state_t o_exch_state,
	input wire psw_msg_t i_access_rx,
	input wire psw_mgmt_req_t i_access_mgmt,
	output psw_msg_t o_access_tx,
	output psw_mgmt_ind_t o_access_ind,
	output psw_access_state_t o_access_state
);
	typedef struct packed
	{
		psw_exch_state_t fsm;
		logic operator_mode;
		logic [7:0] channel;
		logic [4:0] link_id;
		logic [4:0] time_slot;
		psw_msg_t tx;
		psw_mgmt_ind_t ind;
		logic std_start;
		logic std_stop;
		logic opr_start;
		logic opr_stop;
	} psw_exc_state_t;
	logic [1:0] rst_sync_reg;
	logic rst;
	psw_exc_state_t state_reg;
	psw_exc_state_t state_next;
	logic std_first;
	logic std_second;
	logic opr_first;
	logic opr_second;
	logic rx_ack;
	logic rx_reject;
	logic rx_req;
	logic opr_allowed;
	// reset released through two flops so every entity leaves reset together
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_sync_reg <= 2'b00;
		end
		else
		begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst = !rst_sync_reg[1];
	psw_guard_timer #(.CYCLES(STD_GUARD)) u_std_guard_timer (
		.i_clock(i_clock),
		.i_rst(rst),
		.i_start(state_reg.std_start),
		.i_stop(state_reg.std_stop),
		.o_first_expiry(std_first),
		.o_second_expiry(std_second),
		.o_running()
	);
	psw_guard_timer #(.CYCLES(OPR_GUARD)) u_operator_guard_timer (
		.i_clock(i_clock),
		.i_rst(rst),
		.i_start(state_reg.opr_start),
		.i_stop(state_reg.opr_stop),
		.o_first_expiry(opr_first),
		.o_second_expiry(opr_second),
		.o_running()
	);
	psw_access_entity #(.REQ_GUARD(REQ_GUARD)) u_access_entity (
		.i_clock(i_clock),
		.i_rst(rst),
		.i_rx(i_access_rx),
		.i_mgmt(i_access_mgmt),
		.o_tx(o_access_tx),
		.o_ind(o_access_ind),
		.o_state(o_access_state)
	);
	assign o_exch_tx = state_reg.tx;
	assign o_exch_ind = state_reg.ind;
	assign o_exch_state = state_reg.fsm;
	assign rx_ack = i_exch_rx.valid && i_exch_rx.kind == psw_msg_ack;
	assign rx_reject = i_exch_rx.valid && i_exch_rx.kind == psw_msg_reject;
	assign rx_req = i_exch_rx.valid && i_exch_rx.kind == psw_msg_req;
	assign opr_allowed = i_exch_mgmt.os_switch_com &&
		i_exch_mgmt.group == `PSW_OPERATOR_GROUP;
	always_comb
	begin
		state_next = state_reg;
		state_next.tx = '0;
		state_next.ind = '0;
		state_next.std_start = 1'b0;
		state_next.std_stop = 1'b0;
		state_next.opr_start = 1'b0;
		state_next.opr_stop = 1'b0;
		case (state_reg.fsm)
			exch_null_state:
			begin
				if (rx_ack)
				begin
					state_next.ind.ack_ind = 1'b1;
				end
				else if (rx_reject)
				begin
					state_next.ind.reject_ind = 1'b1;
					state_next.ind.cause = i_exch_rx.cause;
				end
				else if (rx_req)
				begin
					state_next.fsm = exch_access_requested_state;
					state_next.channel = i_exch_rx.logical_channel;
					state_next.ind.req_ind = 1'b1;
				end
				else if (opr_allowed)
				begin
					state_next.fsm = exch_initiated_state;
					state_next.operator_mode = 1'b1;
					state_next.channel = i_exch_mgmt.logical_channel;
					state_next.link_id = i_exch_mgmt.link_id;
					state_next.time_slot = i_exch_mgmt.time_slot;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_os_com;
					state_next.tx.logical_channel = i_exch_mgmt.logical_channel;
					state_next.tx.link_id = i_exch_mgmt.link_id;
					state_next.tx.time_slot = i_exch_mgmt.time_slot;
					state_next.opr_start = 1'b1;
				end
				else if (i_exch_mgmt.switch_com)
				begin
					state_next.fsm = exch_initiated_state;
					state_next.operator_mode = 1'b0;
					state_next.channel = i_exch_mgmt.logical_channel;
					state_next.link_id = i_exch_mgmt.link_id;
					state_next.time_slot = i_exch_mgmt.time_slot;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_com;
					state_next.tx.logical_channel = i_exch_mgmt.logical_channel;
					state_next.tx.link_id = i_exch_mgmt.link_id;
					state_next.tx.time_slot = i_exch_mgmt.time_slot;
					state_next.std_start = 1'b1;
				end
			end
			exch_access_requested_state:
			begin
				if (opr_allowed)
				begin
					state_next.fsm = exch_initiated_state;
					state_next.operator_mode = 1'b1;
					state_next.link_id = i_exch_mgmt.link_id;
					state_next.time_slot = i_exch_mgmt.time_slot;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_os_com;
					state_next.tx.logical_channel = i_exch_mgmt.logical_channel;
					state_next.tx.link_id = i_exch_mgmt.link_id;
					state_next.tx.time_slot = i_exch_mgmt.time_slot;
					state_next.channel = i_exch_mgmt.logical_channel;
					state_next.opr_start = 1'b1;
				end
				else if (i_exch_mgmt.switch_com || i_exch_mgmt.accept)
				begin
					state_next.fsm = exch_initiated_state;
					state_next.operator_mode = 1'b0;
					state_next.link_id = i_exch_mgmt.link_id;
					state_next.time_slot = i_exch_mgmt.time_slot;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_com;
					state_next.tx.logical_channel = state_reg.channel;
					state_next.tx.link_id = i_exch_mgmt.link_id;
					state_next.tx.time_slot = i_exch_mgmt.time_slot;
					state_next.std_start = 1'b1;
				end
				else if (i_exch_mgmt.refuse)
				begin
					state_next.fsm = exch_null_state;
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = psw_msg_reject;
					state_next.tx.logical_channel = state_reg.channel;
					state_next.tx.cause = i_exch_mgmt.cause;
				end
			end
			exch_initiated_state:
			begin
				// a request here is dropped by falling through
				if (rx_ack)
				begin
					state_next.fsm = exch_null_state;
					state_next.ind.ack_ind = 1'b1;
					state_next.opr_stop = state_reg.operator_mode;
					state_next.std_stop = !state_reg.operator_mode;
				end
				else if (rx_reject)
				begin
					state_next.fsm = exch_null_state;
					state_next.ind.reject_ind = 1'b1;
					state_next.ind.cause = i_exch_rx.cause;
					state_next.opr_stop = state_reg.operator_mode;
					state_next.std_stop = !state_reg.operator_mode;
				end
				else if (std_first || opr_first)
				begin
					state_next.tx.valid = 1'b1;
					state_next.tx.kind = opr_first ? psw_msg_os_com : psw_msg_com;
					state_next.tx.logical_channel = state_reg.channel;
					state_next.tx.link_id = state_reg.link_id;
					state_next.tx.time_slot = state_reg.time_slot;
					state_next.std_start = std_first;
					state_next.opr_start = opr_first;
				end
				else if (std_second || opr_second)
				begin
					state_next.fsm = exch_null_state;
					state_next.ind.error_ind = 1'b1;
				end
			end
			default:
			begin
				state_next.fsm = exch_null_state;
			end
		endcase
		// expiries and primitives not handled above change nothing
	end
	always_ff @(posedge i_clock)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.fsm <= exch_null_state;
		end
		else
		begin
			state_reg <= state_next;
		end
	end
endmodule

// ---- hdl/psw_guard_timer.sv ----
`include "psw_params.svh"
module psw_guard_timer import psw_pkg::*; #(
	parameter logic [`PSW_TIMER_WIDTH-1:0] CYCLES = `PSW_STD_GUARD_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_start,
	input wire logic i_stop,
	output logic o_first_expiry,
	output logic o_second_expiry,
	output logic o_running
);
	typedef struct packed
	{
		logic running;
		logic expired_once;
		logic [`PSW_TIMER_WIDTH-1:0] count;
	} psw_tmr_state_t;
	psw_tmr_state_t state_reg;
	psw_tmr_state_t state_next;
	logic expiry;
	assign expiry = state_reg.running && (state_reg.count == '0);
	assign o_first_expiry = expiry && !state_reg.expired_once;
	assign o_second_expiry = expiry && state_reg.expired_once;
	assign o_running = state_reg.running;
	always_comb
	begin
		state_next = state_reg;
		if (state_reg.running)
		begin
			state_next.count = state_reg.count - 1'b1;
		end
		if (expiry)
		begin
			state_next.running = 1'b0;
			state_next.expired_once = !state_reg.expired_once;
		end
		// start is a cycle late, so it keeps the memory; the second expiry clears it
		if (i_start)
		begin
			state_next.running = 1'b1;
			state_next.count = CYCLES - 1'b1;
		end
		if (i_stop)
		begin
			state_next.running = 1'b0;
			state_next.expired_once = 1'b0;
		end
	end
	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end
endmodule

// ---- hdl/psw_params.svh ----
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH
// Operation
// - first standard guard expiry in initiated state resends switch-over command, restarts timer.
// - second standard guard expiry in initiated state flags error, returns exchange to null.
// - exchange guard expiry outside initiated state does nothing.
// - acknowledge in exchange null state is passed to management, state kept.
// - reject in exchange null state passes cause to management, state kept.
// - operator command from null or access-requested sends operator command, starts timer, initiates.
// - operator switch-over only for protection group 2; pre-empts an active target.
// - access null receiving operator command enters commanded state, indicates to management.
// - access management accept sends acknowledge, access returns to null.
// - acknowledge during operator switch-over indicates, stops operator timer, exchange null.
// - switch-over request while exchange initiated is discarded, no state change.
// - access refusal sends reject with cause; target-occupied cause never for operator command.
// - reject during operator switch-over indicates, stops operator timer, exchange null.
// - first operator guard expiry resends operator command and restarts timer.
// - second operator guard expiry flags error, exchange returns to null.
// - unexpected management primitives are ignored with no state change.
// - access null switch-over request sends request, starts request timer, enters requested.
// - failure request names only channel; no preference means zero link and slot.
// - exchange null receiving request enters access-requested state, indicates to management.
// - exchange accept of access request sends command, initiates, starts standard timer.
// - access requested receiving either command enters commanded, indicates, stops request timer.
// - acknowledge after access request indicates, stops standard timer, exchange null.
// - request timer first expiry resends request and restarts; second errors to null.
// - exchange refusal in access-requested state sends reject with cause, goes null.
`define PSW_STD_GUARD_CYCLES 32'd40000
`define PSW_OPR_GUARD_CYCLES 32'd40000
`define PSW_REQ_GUARD_CYCLES 32'd40000
`define PSW_TIMER_WIDTH 32
`define PSW_OPERATOR_GROUP 2'd2
`define PSW_CAUSE_TARGET_OCCUPIED 8'h05
`define PSW_CAUSE_NOT_ALLOWED 8'h04
`endif

// ---- hdl/psw_pkg.sv ----
package psw_pkg;
	typedef enum logic [2:0]
	{
		exch_null_state = 3'b001,
		exch_initiated_state = 3'b010,
		exch_access_requested_state = 3'b100
	} psw_exch_state_t;
	typedef enum logic [2:0]
	{
		access_null_state = 3'b001,
		access_requested_state = 3'b010,
		access_commanded_state = 3'b100
	} psw_access_state_t;
	typedef enum logic [2:0]
	{
		psw_msg_none = 3'h0,
		psw_msg_com = 3'h1,
		psw_msg_os_com = 3'h2,
		psw_msg_req = 3'h3,
		psw_msg_ack = 3'h4,
		psw_msg_reject = 3'h5
	} psw_msg_kind_t;
	typedef struct packed
	{
		logic valid;
		psw_msg_kind_t kind;
		logic [7:0] logical_channel;
		logic [4:0] link_id;
		logic [4:0] time_slot;
		logic [7:0] cause;
	} psw_msg_t;
	// management primitive toward the protocol entity
	typedef struct packed
	{
		logic switch_com;
		logic os_switch_com;
		logic switch_req;
		logic accept;
		logic refuse;
		logic has_preference;
		logic [1:0] group;
		logic [7:0] logical_channel;
		logic [4:0] link_id;
		logic [4:0] time_slot;
		logic [7:0] cause;
	} psw_mgmt_req_t;
	// indications toward management, one-cycle pulses
	typedef struct packed
	{
		logic com_ind;
		logic os_com_ind;
		logic req_ind;
		logic ack_ind;
		logic reject_ind;
		logic error_ind;
		logic [7:0] cause;
	} psw_mgmt_ind_t;
endpackage

// ---- sim/psw_peer_model.sv ----
`include "psw_params.svh"
module psw_peer_model import psw_pkg::*;
(
	input wire logic i_clock,
	input wire psw_msg_t i_msg,
	input wire logic [1:0] i_mode,
	input wire logic i_slow,
	output psw_msg_t o_msg
);
	timeunit 1ns;
	timeprecision 1ps;
	psw_msg_t last;
	psw_msg_t idle;
	logic [7:0] lc;
	// mode 0 stays silent so the guard timers run out
	initial
	begin
		o_msg = '0;
		forever
		begin
			@(posedge i_clock);
			if (i_msg.valid === 1'b1 && i_msg.kind inside {psw_msg_com, psw_msg_os_com}
				&& i_mode != 2'd0)
			begin
				lc = i_msg.logical_channel;
				repeat (i_slow ? 8 : 1) @(posedge i_clock);
				@(negedge i_clock);
				last = '0;
				last.valid = 1'b1;
				last.kind = (i_mode == 2'd1) ? psw_msg_ack : psw_msg_reject;
				last.logical_channel = lc;
				last.cause = `PSW_CAUSE_NOT_ALLOWED;
				o_msg = last;
				@(negedge i_clock);
				// released fields flip so stale data never looks valid
				idle = ~last;
				idle.valid = 1'b0;
				o_msg = idle;
			end
		end
	end
endmodule

// ---- sim/psw_props.sv ----
`include "psw_params.svh"
module psw_props import psw_pkg::*; #(
	parameter logic [`PSW_TIMER_WIDTH-1:0] STD_GUARD = `PSW_STD_GUARD_CYCLES,
	parameter logic [`PSW_TIMER_WIDTH-1:0] OPR_GUARD = `PSW_OPR_GUARD_CYCLES,
	parameter logic [`PSW_TIMER_WIDTH-1:0] REQ_GUARD = `PSW_REQ_GUARD_CYCLES
)
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire psw_msg_t i_exch_rx,
	input wire psw_mgmt_req_t i_exch_mgmt,
	input wire psw_msg_t o_exch_tx,
	input wire psw_mgmt_ind_t o_exch_ind,
	input wire psw_exch_state_t o_exch_state,
	input wire psw_msg_t i_access_rx,
	input wire psw_mgmt_req_t i_access_mgmt,
	input wire psw_msg_t o_access_tx,
	input wire psw_mgmt_ind_t o_access_ind,
	input wire psw_access_state_t o_access_state
);
	// twice the sum of both guards plus 8 cycles of slack
	localparam int MAX_INIT = int'(2 * (STD_GUARD + OPR_GUARD) + 8);
	logic [31:0] init_cnt_reg;
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
			init_cnt_reg <= 32'h0;
		else if (o_exch_state == exch_initiated_state)
			init_cnt_reg <= init_cnt_reg + 32'h1;
		else
			init_cnt_reg <= 32'h0;
	end
	a_ack_indicated: assert property (
		i_exch_rx.valid && i_exch_rx.kind == psw_msg_ack
		&& o_exch_state != exch_access_requested_state
		|=> o_exch_ind.ack_ind && o_exch_state == exch_null_state)
		else $error("ack not indicated");
	a_reject_cause: assert property (
		i_exch_rx.valid && i_exch_rx.kind == psw_msg_reject
		&& o_exch_state != exch_access_requested_state
		|=> o_exch_ind.reject_ind && o_exch_ind.cause == $past(i_exch_rx.cause)
		&& o_exch_state == exch_null_state)
		else $error("reject not indicated");
	a_req_discarded: assert property (
		i_exch_rx.valid && i_exch_rx.kind == psw_msg_req && o_exch_state == exch_initiated_state
		|=> o_exch_state == exch_initiated_state && !o_exch_ind.req_ind)
		else $error("request not discarded");
	a_req_entered: assert property (
		i_exch_rx.valid && i_exch_rx.kind == psw_msg_req && o_exch_state == exch_null_state
		|=> o_exch_state == exch_access_requested_state && o_exch_ind.req_ind)
		else $error("request not taken");
	a_os_sent: assert property (
		!i_exch_rx.valid && i_exch_mgmt.os_switch_com && i_exch_mgmt.group == `PSW_OPERATOR_GROUP
		&& o_exch_state != exch_initiated_state
		|=> o_exch_tx.valid && o_exch_tx.kind == psw_msg_os_com
		&& o_exch_tx.logical_channel == $past(i_exch_mgmt.logical_channel)
		&& o_exch_state == exch_initiated_state)
		else $error("operator command not sent");
	a_os_group_only: assert property (
		!i_exch_rx.valid && i_exch_mgmt.os_switch_com && i_exch_mgmt.group != `PSW_OPERATOR_GROUP
		&& o_exch_state == exch_null_state
		|=> o_exch_state == exch_null_state && !o_exch_tx.valid)
		else $error("operator command outside its group");
	a_error_source: assert property (
		o_exch_ind.error_ind
		|-> o_exch_state == exch_null_state && $past(o_exch_state) == exch_initiated_state)
		else $error("error outside initiated state");
	a_init_bounded: assert property (init_cnt_reg <= MAX_INIT)
		else $error("initiated state never left");
	a_access_req: assert property (
		!i_access_rx.valid && i_access_mgmt.switch_req && o_access_state == access_null_state
		|=> o_access_tx.valid && o_access_tx.kind == psw_msg_req
		&& o_access_state == access_requested_state && ($past(i_access_mgmt.has_preference)
		|| o_access_tx.link_id == 5'h0 && o_access_tx.time_slot == 5'h0))
		else $error("access request wrong");
	a_access_ack: assert property (
		!i_access_rx.valid && i_access_mgmt.accept && o_access_state == access_commanded_state
		|=> o_access_tx.valid && o_access_tx.kind == psw_msg_ack
		&& o_access_state == access_null_state)
		else $error("access ack wrong");
endmodule
bind psw_exchange_entity psw_props #(.STD_GUARD(STD_GUARD), .OPR_GUARD(OPR_GUARD),
	.REQ_GUARD(REQ_GUARD)) u_props (.i_clock(i_clock), .i_resetn(i_resetn),
	.i_exch_rx(i_exch_rx), .i_exch_mgmt(i_exch_mgmt), .o_exch_tx(o_exch_tx),
	.o_exch_ind(o_exch_ind), .o_exch_state(o_exch_state), .i_access_rx(i_access_rx),
	.i_access_mgmt(i_access_mgmt), .o_access_tx(o_access_tx), .o_access_ind(o_access_ind),
	.o_access_state(o_access_state));

// ---- sim/tb_psw_exchange_entity.sv ----
`include "psw_params.svh"
module tb_psw_exchange_entity import psw_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] G = 32'd20;
	logic i_clock, i_resetn, slow;
	logic [1:0] mode;
	psw_msg_t xrx_tb, peer_msg, arx, o_exch_tx, o_access_tx;
	wire psw_msg_t xrx;
	psw_mgmt_req_t xm, am;
	psw_mgmt_ind_t o_exch_ind, o_access_ind;
	psw_exch_state_t o_exch_state;
	psw_access_state_t o_access_state;
	int n_errors, n_compared;
	assign xrx = (peer_msg.valid === 1'b1) ? peer_msg : xrx_tb;
	psw_exchange_entity #(.STD_GUARD(G), .OPR_GUARD(G), .REQ_GUARD(G)) uut (
		.i_clock(i_clock), .i_resetn(i_resetn), .i_exch_rx(xrx), .i_exch_mgmt(xm),
		.o_exch_tx(o_exch_tx), .o_exch_ind(o_exch_ind), .o_exch_state(o_exch_state),
		.i_access_rx(arx), .i_access_mgmt(am), .o_access_tx(o_access_tx),
		.o_access_ind(o_access_ind), .o_access_state(o_access_state));
	psw_peer_model peer (.i_clock(i_clock), .i_msg(o_exch_tx), .i_mode(mode),
		.i_slow(slow), .o_msg(peer_msg));
	initial
	begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	task report_and_stop;
		$display("errors=%0d compared=%0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk3(input logic [2:0] got, input logic [2:0] exp);
		chk8({5'h0, got}, {5'h0, exp});
	endtask
	task chk_flag(input logic got, input logic exp);
		chk8({7'h0, got}, {7'h0, exp});
	endtask
	task mgmt(input bit acc, input psw_mgmt_req_t m);
		@(negedge i_clock);
		if (acc)
			am = m;
		else
			xm = m;
		@(negedge i_clock);
		if (acc)
			am = '0;
		else
			xm = '0;
	endtask
	// idle message lines show the inverse, never the last message
	task msg(input bit acc, input psw_msg_kind_t k, input logic [7:0] c);
		psw_msg_t m;
		m = '{valid:1'b1, kind:k, cause:c, logical_channel:8'h31, default:'0};
		@(negedge i_clock);
		if (acc)
			arx = m;
		else
			xrx_tb = m;
		m = ~m;
		m.valid = 1'b0;
		@(negedge i_clock);
		if (acc)
			arx = m;
		else
			xrx_tb = m;
	endtask
	task wait_ev(input int sel);
		int i;
		for (i = 0; i < 200; i++)
		begin
			@(negedge i_clock);
			if (sel == 0 && o_exch_tx.valid === 1'b1 || sel == 1 && o_exch_ind.error_ind === 1'b1
				|| sel == 2 && o_access_tx.valid === 1'b1
				|| sel == 3 && o_access_ind.error_ind === 1'b1
				|| sel == 4 && o_exch_ind.ack_ind === 1'b1
				|| sel == 5 && o_exch_ind.reject_ind === 1'b1)
				break;
		end
		chk_flag(i < 200, 1'b1);
	endtask
	task quiet(input bit acc);
		logic seen;
		seen = 1'b0;
		repeat (3 * G) @(negedge i_clock) seen |= acc ? o_access_tx.valid : o_exch_tx.valid;
		chk_flag(seen, 1'b0);
	endtask
	task s_null_msgs;
		msg(0, psw_msg_ack, 8'h0);
		chk_flag(o_exch_ind.ack_ind, 1'b1);
		chk3(o_exch_state, exch_null_state);
		msg(0, psw_msg_reject, 8'h33);
		chk8(o_exch_ind.cause, 8'h33);
		chk3(o_exch_state, exch_null_state);
	endtask
	task s_std_retry;
		mode = 2'd0;
		mgmt(0, '{switch_com:1'b1, logical_channel:8'h11, default:'0});
		chk3(o_exch_state, exch_initiated_state);
		wait_ev(0);
		chk3(o_exch_tx.kind, psw_msg_com);
		msg(0, psw_msg_req, 8'h0);
		chk_flag(o_exch_ind.req_ind, 1'b0);
		chk3(o_exch_state, exch_initiated_state);
		wait_ev(1);
		chk3(o_exch_state, exch_null_state);
		mgmt(0, '{accept:1'b1, default:'0});
		chk3(o_exch_state, exch_null_state);
		quiet(0);
	endtask
	task s_operator;
		mgmt(0, '{os_switch_com:1'b1, group:2'd1, default:'0});
		chk3(o_exch_state, exch_null_state);
		mode = 2'd1;
		slow = 1'b1;
		mgmt(0, '{os_switch_com:1'b1, group:2'd2, logical_channel:8'h21, link_id:5'h3,
			time_slot:5'h7, default:'0});
		chk3(o_exch_tx.kind, psw_msg_os_com);
		chk8(o_exch_tx.logical_channel, 8'h21);
		chk_flag(o_exch_tx.link_id == 5'h3 && o_exch_tx.time_slot == 5'h7, 1'b1);
		wait_ev(4);
		chk3(o_exch_state, exch_null_state);
		mode = 2'd2;
		slow = 1'b0;
		quiet(0);
		mgmt(0, '{os_switch_com:1'b1, group:2'd2, default:'0});
		wait_ev(5);
		chk8(o_exch_ind.cause, `PSW_CAUSE_NOT_ALLOWED);
		chk3(o_exch_state, exch_null_state);
		mode = 2'd0;
		mgmt(0, '{os_switch_com:1'b1, group:2'd2, default:'0});
		wait_ev(0);
		chk3(o_exch_tx.kind, psw_msg_os_com);
		wait_ev(1);
		chk3(o_exch_state, exch_null_state);
	endtask
	task s_access_req;
		msg(0, psw_msg_req, 8'h0);
		chk_flag(o_exch_ind.req_ind, 1'b1);
		chk3(o_exch_state, exch_access_requested_state);
		mgmt(0, '{refuse:1'b1, cause:8'h42, default:'0});
		chk3(o_exch_tx.kind, psw_msg_reject);
		chk8(o_exch_tx.cause, 8'h42);
		chk3(o_exch_state, exch_null_state);
		msg(0, psw_msg_req, 8'h0);
		mode = 2'd1;
		mgmt(0, '{accept:1'b1, default:'0});
		chk3(o_exch_tx.kind, psw_msg_com);
		chk3(o_exch_state, exch_initiated_state);
		wait_ev(4);
		chk3(o_exch_state, exch_null_state);
		mode = 2'd0;
		msg(0, psw_msg_req, 8'h0);
		mgmt(0, '{os_switch_com:1'b1, group:2'd2, default:'0});
		chk3(o_exch_tx.kind, psw_msg_os_com);
		wait_ev(1);
	endtask
	task s_access_side;
		mgmt(1, '{switch_req:1'b1, logical_channel:8'h31, link_id:5'h9, time_slot:5'h4,
			default:'0});
		chk8(o_access_tx.logical_channel, 8'h31);
		chk_flag(o_access_tx.link_id == 5'h0 && o_access_tx.time_slot == 5'h0, 1'b1);
		chk3(o_access_state, access_requested_state);
		wait_ev(2);
		chk3(o_access_tx.kind, psw_msg_req);
		wait_ev(3);
		chk3(o_access_state, access_null_state);
		mgmt(1, '{switch_req:1'b1, has_preference:1'b1, link_id:5'h9, time_slot:5'h4,
			default:'0});
		chk_flag(o_access_tx.link_id == 5'h9 && o_access_tx.time_slot == 5'h4, 1'b1);
		msg(1, psw_msg_com, 8'h0);
		chk_flag(o_access_ind.com_ind, 1'b1);
		chk3(o_access_state, access_commanded_state);
		quiet(1);
		mgmt(1, '{accept:1'b1, default:'0});
		chk3(o_access_tx.kind, psw_msg_ack);
		chk3(o_access_state, access_null_state);
		msg(1, psw_msg_os_com, 8'h0);
		chk_flag(o_access_ind.os_com_ind, 1'b1);
		chk3(o_access_state, access_commanded_state);
		mgmt(1, '{refuse:1'b1, cause:`PSW_CAUSE_TARGET_OCCUPIED, default:'0});
		chk3(o_access_tx.kind, psw_msg_reject);
		chk8(o_access_tx.cause, `PSW_CAUSE_NOT_ALLOWED);
	endtask
	initial
	begin
		#(25 * 6000);
		n_errors++;
		report_and_stop;
	end
	initial
	begin
		xrx_tb = '0;
		arx = '0;
		xm = '0;
		am = '0;
		mode = 2'd0;
		slow = 1'b0;
		n_errors = 0;
		n_compared = 0;
		i_resetn = 1'b0;
		repeat (6) @(negedge i_clock);
		i_resetn = 1'b1;
		repeat (5) @(negedge i_clock);
		s_null_msgs;
		s_std_retry;
		s_operator;
		s_access_req;
		s_access_side;
		report_and_stop;
	end
endmodule
